// *** verilog/flash_id_pkg.sv ***
// shared constants for the read-parameter and identification command block
package flash_id_pkg;
    // instruction codes
    localparam logic [7:0] CMD_READ            = 8'h03;
    localparam logic [7:0] CMD_SET_READ_PARAMS = 8'hc0;
    localparam logic [7:0] CMD_LEGACY_ID       = 8'hab;
    localparam logic [7:0] CMD_STD_ID          = 8'h9f;
    localparam logic [7:0] CMD_STD_ID_QUAD     = 8'haf;
    localparam logic [7:0] CMD_MAKER_DEV_ID    = 8'h90;

    // read register layout
    localparam int BURST_LSB = 0;
    localparam int WRAP_BIT  = 2;
    localparam int DRIVE_LSB = 5;
    localparam logic [2:0] DRIVE_HALF     = 3'h5;
    localparam logic [7:0] READ_REG_RESET = {DRIVE_HALF, 5'h00};

    // bytes following the instruction before output starts, minus one
    localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;

    // serial shift counts: last count of a byte per edge width
    localparam logic [2:0] LAST_CNT_SINGLE = 3'h7;
    localparam logic [2:0] LAST_CNT_QUAD   = 3'h1;

    // register map, byte addresses
    localparam logic [3:0] OFS_CTRL     = 4'h0;
    localparam logic [3:0] OFS_PWRDN    = 4'h4;
    localparam logic [3:0] OFS_READ_REG = 4'h8;
    localparam int CTRL_QUAD_BIT = 0;
    localparam int CTRL_WIP_BIT  = 1;

    // output enable patterns
    localparam logic [3:0] OE_SINGLE = 4'h2;
    localparam logic [3:0] OE_QUAD   = 4'hf;

    // identification codes, values arbitrary
    localparam logic [7:0]  MAKER_CODE_DEF   = 8'h5a;
    localparam logic [7:0]  DEVICE_CODE_DEF  = 8'h3c;
    localparam logic [15:0] TYPE_CAP_CODE_DEF = 16'h2a41;

    typedef enum logic [1:0] {
        K_READ,
        K_LEGACY,
        K_STD,
        K_MD
    } cmd_kind_t;
endpackage

// *** verilog/burst_addr_step.sv ***
// next read address, linear or wrapped within an aligned burst
`timescale 1ns/100ps
module burst_addr_step (
    input  wire logic [23:0] addr,
    input  wire logic        wrap_en,
    input  wire logic [1:0]  burst_size,
    output logic      [23:0] next_addr
);
    logic [23:0] mask;
    logic [23:0] inc;

    always_comb begin
        // burst of 8, 16, 32 or 64 bytes
        mask = 24'h000007;
        unique case (burst_size)
            2'h0: mask = 24'h000007;
            2'h1: mask = 24'h00000f;
            2'h2: mask = 24'h00001f;
            2'h3: mask = 24'h00003f;
        endcase
        inc = addr + 24'h000001;
        if (wrap_en) begin
            // upper bits held, low bits roll over inside the burst
            next_addr = (addr & ~mask) | (inc & mask); // see R5 see R19
        end else begin
            next_addr = inc; // see R4
        end
    end
endmodule

// *** verilog/flash_read_params_and_id.sv ***
// serial flash command block: read parameters, wrapped reads, identification reads
//
// Overview of operation
// R1: three-bit drive strength set only by parameter command
// R2: drive strength resets to half drive
// R3: wrap enable and two-bit burst size held
// R4: linear reads step address by one
// R5: wrapped reads roll over inside burst boundary
// R6: wrapped read runs until chip enable rises
// R7: parameter byte 0-3 linear, 4-7 wrap
// R8: wrap persists until cleared or reset
// R9: all reads honour wrap setting
// R10: legacy id takes three dummy bytes first
// R11: legacy id repeats msb first until deselect
// R12: standard id 9f, also af in quad
// R13: standard id three bytes repeat cyclically
// R14: host sends two dummies and address byte
// R15: address bit zero picks first id byte
// R16: maker and device bytes alternate until deselect
// R17: legacy id releases power-down, ignored when busy
// R18: quad mode carries nibbles, high first
// R19: wrap boundary aligned to burst length
`timescale 1ns/100ps
module flash_read_params_and_id (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    // serial link pins
    input  wire logic        ce_n,
    input  wire logic        sck,
    input  wire logic [3:0]  io_in,
    output logic      [3:0]  io_out,
    output logic      [3:0]  io_oe,
    output logic      [2:0]  drive_strength,
    // memory array read port
    output logic      [23:0] array_rd_addr,
    input  wire logic [7:0]  array_rd_data,
    // avalon-mm slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest
);
    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_SRP,
        ST_DATA,
        ST_IGNORE
    } link_state_t;

    link_state_t             state;
    flash_id_pkg::cmd_kind_t kind;

    logic        ce_s1, ce_s2;
    logic        sck_s1, sck_s2, sck_s3;
    logic [3:0]  io_s1, io_s2;
    logic        sck_rise, sck_fall, active;
    logic [7:0]  in_shift;
    logic [2:0]  in_cnt;
    logic [7:0]  new_byte;
    logic        byte_done;
    logic [1:0]  bytes_left;
    logic        md_a0;
    logic [7:0]  read_reg;
    logic        power_down;
    logic        quad_mode;
    logic        write_in_progress_flag;
    logic [7:0]  out_shift;
    logic [2:0]  out_cnt;
    logic [1:0]  out_idx;
    logic [7:0]  next_out;
    logic [7:0]  byte_now;
    logic        out_last;
    logic        out_edge;
    logic        adv_byte;
    logic        adv_read;
    logic [23:0] step_addr;
    logic        access;
    logic        sw_pd_set;
    logic        pd_release;

    // true when the shift count has reached the last edge of a byte
    function automatic logic at_last(input logic quad, input logic [2:0] cnt);
        at_last = quad ? (cnt == flash_id_pkg::LAST_CNT_QUAD)
                       : (cnt == flash_id_pkg::LAST_CNT_SINGLE);
    endfunction

    function automatic logic reg_hit(input logic [3:0] addr, input logic [3:0] ofs);
        reg_hit = (addr == ofs);
    endfunction

    // pin synchronisers; first stages feed only the second stages
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ce_s1  <= 1'b1;
            ce_s2  <= 1'b1;
            sck_s1 <= 1'b0;
            sck_s2 <= 1'b0;
            sck_s3 <= 1'b0;
            io_s1  <= 4'h0;
            io_s2  <= 4'h0;
        end else begin
            ce_s1  <= ce_n;
            ce_s2  <= ce_s1;
            sck_s1 <= sck;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
            io_s1  <= io_in;
            io_s2  <= io_s1;
        end
    end

    assign active    = ~ce_s2;
    assign sck_rise  = active & sck_s2 & ~sck_s3;
    assign sck_fall  = active & ~sck_s2 & sck_s3;
    // quad takes a nibble per edge, high nibble first
    assign new_byte  = quad_mode ? {in_shift[3:0], io_s2}
                                 : {in_shift[6:0], io_s2[0]}; // see R18
    assign byte_done = sck_rise && (state != ST_DATA) && at_last(quad_mode, in_cnt);

    // input shifter, sampled on rising serial clock
    always_ff @(posedge mclk) begin
        if (!rst_n || ce_s2) begin
            in_shift <= 8'h00;
            in_cnt   <= 3'h0;
        end else if (sck_rise && state != ST_DATA) begin
            in_shift <= new_byte; // see R10
            in_cnt   <= at_last(quad_mode, in_cnt) ? 3'h0 : in_cnt + 3'h1;
        end
    end

    // command sequencer
    always_ff @(posedge mclk) begin
        if (!rst_n || ce_s2) begin
            state      <= ST_CMD; // see R6 see R11
            kind       <= flash_id_pkg::K_READ;
            bytes_left <= 2'h0;
            md_a0      <= 1'b0;
        end else if (byte_done) begin
            unique case (state)
                ST_CMD: begin
                    bytes_left <= flash_id_pkg::ADDR_BYTES_LAST;
                    if (power_down && new_byte != flash_id_pkg::CMD_LEGACY_ID) begin
                        state <= ST_IGNORE;
                    end else if (new_byte == flash_id_pkg::CMD_READ) begin
                        kind  <= flash_id_pkg::K_READ; // see R9
                        state <= ST_ADDR;
                    end else if (new_byte == flash_id_pkg::CMD_SET_READ_PARAMS) begin
                        state <= ST_SRP; // see R1
                    end else if (new_byte == flash_id_pkg::CMD_LEGACY_ID) begin
                        kind  <= flash_id_pkg::K_LEGACY;
                        state <= write_in_progress_flag ? ST_IGNORE : ST_ADDR; // see R17
                    end else if (new_byte == flash_id_pkg::CMD_STD_ID ||
                                 (quad_mode && new_byte == flash_id_pkg::CMD_STD_ID_QUAD)) begin
                        kind  <= flash_id_pkg::K_STD; // see R12
                        state <= ST_DATA;
                    end else if (new_byte == flash_id_pkg::CMD_MAKER_DEV_ID) begin
                        kind  <= flash_id_pkg::K_MD; // see R14
                        state <= ST_ADDR;
                    end else begin
                        state <= ST_IGNORE;
                    end
                end
                ST_ADDR: begin
                    bytes_left <= bytes_left - 2'h1;
                    md_a0      <= new_byte[0]; // see R15
                    if (bytes_left == 2'h0) begin
                        state <= ST_DATA; // see R10
                    end
                end
                ST_SRP: begin
                    state <= ST_IGNORE;
                end
                ST_DATA: begin
                    state <= ST_DATA;
                end
                ST_IGNORE: begin
                    state <= ST_IGNORE;
                end
            endcase
        end
    end

    // volatile read register
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            read_reg <= flash_id_pkg::READ_REG_RESET; // see R2 see R8
        end else if (byte_done && state == ST_SRP) begin
            read_reg <= new_byte; // see R1 see R3 see R7 see R8
        end
    end

    assign drive_strength = read_reg[flash_id_pkg::DRIVE_LSB +: 3];

    // deep power-down; a software entry wins over a same-cycle release
    assign pd_release = byte_done && state == ST_CMD && !write_in_progress_flag &&
                        new_byte == flash_id_pkg::CMD_LEGACY_ID;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            power_down <= 1'b0;
        end else if (sw_pd_set) begin
            power_down <= 1'b1;
        end else if (pd_release) begin
            power_down <= 1'b0; // see R17
        end
    end

    // output byte selection
    always_comb begin
        next_out = array_rd_data;
        unique case (kind)
            flash_id_pkg::K_READ:   next_out = array_rd_data;
            flash_id_pkg::K_LEGACY: next_out = flash_id_pkg::DEVICE_CODE_DEF; // see R11
            flash_id_pkg::K_STD: begin
                if (out_idx == 2'h0) begin
                    next_out = flash_id_pkg::MAKER_CODE_DEF; // see R12
                end else if (out_idx == 2'h1) begin
                    next_out = flash_id_pkg::TYPE_CAP_CODE_DEF[15:8];
                end else begin
                    next_out = flash_id_pkg::TYPE_CAP_CODE_DEF[7:0];
                end
            end
            flash_id_pkg::K_MD: begin
                next_out = (out_idx[0] ^ md_a0) ? flash_id_pkg::DEVICE_CODE_DEF
                                                : flash_id_pkg::MAKER_CODE_DEF; // see R15
            end
        endcase
    end

    assign byte_now = (out_cnt == 3'h0) ? next_out : out_shift;
    assign out_last = at_last(quad_mode, out_cnt);
    assign out_edge = sck_fall && state == ST_DATA;
    assign adv_byte = out_edge && out_last;
    assign adv_read = adv_byte && kind == flash_id_pkg::K_READ;

    // output shifter, driven on falling serial clock, msb first
    always_ff @(posedge mclk) begin
        if (!rst_n || ce_s2) begin
            io_out    <= 4'h0;
            io_oe     <= 4'h0; // see R6
            out_shift <= 8'h00;
            out_cnt   <= 3'h0;
        end else if (out_edge) begin
            if (quad_mode) begin
                io_out    <= byte_now[7:4]; // see R18
                io_oe     <= flash_id_pkg::OE_QUAD;
                out_shift <= {byte_now[3:0], 4'h0};
            end else begin
                io_out    <= {2'h0, byte_now[7], 1'b0}; // see R11
                io_oe     <= flash_id_pkg::OE_SINGLE;
                out_shift <= {byte_now[6:0], 1'b0};
            end
            out_cnt <= out_last ? 3'h0 : out_cnt + 3'h1;
        end
    end

    // byte index for the repeating identification sequences
    always_ff @(posedge mclk) begin
        if (!rst_n || ce_s2) begin
            out_idx <= 2'h0;
        end else if (adv_byte) begin
            if (kind == flash_id_pkg::K_STD) begin
                out_idx <= (out_idx == 2'h2) ? 2'h0 : out_idx + 2'h1; // see R13
            end else begin
                out_idx <= {1'b0, ~out_idx[0]}; // see R16
            end
        end
    end

    burst_addr_step u_step (
        .addr       (array_rd_addr),
        .wrap_en    (read_reg[flash_id_pkg::WRAP_BIT]),
        .burst_size (read_reg[flash_id_pkg::BURST_LSB +: 2]),
        .next_addr  (step_addr)
    );

    // read address: assembled from address bytes, then stepped per byte
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            array_rd_addr <= 24'h000000;
        end else if (byte_done && state == ST_ADDR) begin
            array_rd_addr <= {array_rd_addr[15:0], new_byte};
        end else if (adv_read) begin
            array_rd_addr <= step_addr; // see R4 see R5 see R9
        end
    end

    // avalon-mm slave: one wait cycle per access
    assign access    = (avs_read || avs_write) && !avs_waitrequest;
    assign sw_pd_set = access && avs_write && avs_byteenable[0] && avs_writedata[0] &&
                       reg_hit(avs_address, flash_id_pkg::OFS_PWRDN);

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avs_waitrequest <= 1'b1;
        end else begin
            avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
        end
    end

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            avs_readdata <= 32'h00000000;
        end else if (avs_read && avs_waitrequest) begin
            if (reg_hit(avs_address, flash_id_pkg::OFS_CTRL)) begin
                avs_readdata <= {30'h0, write_in_progress_flag, quad_mode};
            end else if (reg_hit(avs_address, flash_id_pkg::OFS_PWRDN)) begin
                avs_readdata <= {31'h0, power_down};
            end else if (reg_hit(avs_address, flash_id_pkg::OFS_READ_REG)) begin
                avs_readdata <= {24'h0, read_reg};
            end else begin
                avs_readdata <= 32'h00000000;
            end
        end
    end

    // control bits; changing quad mode mid-frame corrupts that frame
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            quad_mode              <= 1'b0;
            write_in_progress_flag <= 1'b0;
        end else if (access && avs_write && avs_byteenable[0] &&
                     reg_hit(avs_address, flash_id_pkg::OFS_CTRL)) begin
            quad_mode              <= avs_writedata[flash_id_pkg::CTRL_QUAD_BIT];
            write_in_progress_flag <= avs_writedata[flash_id_pkg::CTRL_WIP_BIT];
        end
    end

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    a_params_stored: assert property ( // see R7
        (byte_done && state == ST_SRP) |=> read_reg == $past(new_byte))
        else $error("parameter byte not stored");
    a_reset_default: assert property ( // see R2
        $rose(rst_n) |-> read_reg == flash_id_pkg::READ_REG_RESET)
        else $error("read register not at reset value");
    a_linear_step: assert property ( // see R4
        (adv_read && !read_reg[flash_id_pkg::WRAP_BIT])
        |=> array_rd_addr == $past(array_rd_addr) + 24'h000001)
        else $error("linear address did not step by one");
    a_wrap_upper_held: assert property ( // see R19
        (adv_read && read_reg[flash_id_pkg::WRAP_BIT])
        |=> array_rd_addr[23:6] == $past(array_rd_addr[23:6]))
        else $error("wrap changed bits above the burst");
    a_deselect_quiet: assert property ( // see R6
        ce_s2 |=> (io_oe == 4'h0 && state == ST_CMD))
        else $error("outputs not released on deselect");
    a_busy_ignores_id: assert property ( // see R17
        (byte_done && state == ST_CMD && write_in_progress_flag &&
         new_byte == flash_id_pkg::CMD_LEGACY_ID) |=> state == ST_IGNORE ##1 $stable(power_down))
        else $error("legacy id acted while busy");
    a_quad_only_alias: assert property ( // see R12
        (byte_done && state == ST_CMD && !quad_mode && !power_down &&
         new_byte == flash_id_pkg::CMD_STD_ID_QUAD) |=> state == ST_IGNORE)
        else $error("quad id alias accepted in single mode");
    a_std_index_range: assert property ( // see R13
        (kind == flash_id_pkg::K_STD) |-> out_idx != 2'h3)
        else $error("standard id index out of range");
    a_md_first_byte: assert property ( // see R15
        (out_edge && kind == flash_id_pkg::K_MD && out_cnt == 3'h0 && out_idx == 2'h0)
        |=> quad_mode || out_shift[7:1] == (md_a0 ? flash_id_pkg::DEVICE_CODE_DEF[6:0]
                                                  : flash_id_pkg::MAKER_CODE_DEF[6:0]))
        else $error("wrong first maker or device byte");
    a_wait_one_cycle: assert property (
        ((avs_read || avs_write) && avs_waitrequest) |=> !avs_waitrequest)
        else $error("waitrequest not released after one cycle");

    c_wrap_read: cover property (adv_read && read_reg[flash_id_pkg::WRAP_BIT]);
    c_legacy_id: cover property (adv_byte && kind == flash_id_pkg::K_LEGACY);
    c_std_loop: cover property (adv_byte && kind == flash_id_pkg::K_STD && out_idx == 2'h2);
    c_md_swap: cover property (adv_byte && kind == flash_id_pkg::K_MD && md_a0);
endmodule

// *** bench/spi_host_model.sv ***
// host-side serial flash controller model that drives the link pins
`timescale 1ns/100ps
module spi_host_model (
    input  wire logic       mclk,
    output logic            ce_n,
    output logic            sck,
    output logic      [3:0] io_in,
    input  wire logic [3:0] io_out,
    input  wire logic [3:0] io_oe
);
    logic [3:0] oe_seen;

    initial begin
        ce_n    = 1'b1;
        sck     = 1'b0;
        io_in   = 4'h0;
        oe_seen = 4'h0;
    end

    // one link clock: data set at the fall, output taken late in the high phase
    task automatic tick(input logic [3:0] d, output logic [3:0] q);
        sck   <= 1'b0;
        io_in <= d;
        repeat (4) @(posedge mclk);
        sck <= 1'b1;
        repeat (3) @(posedge mclk);
        q       = io_out;
        oe_seen = oe_seen | io_oe;
        @(posedge mclk);
    endtask

    task automatic open_frame();
        ce_n    <= 1'b0;
        oe_seen = 4'h0;
        repeat (4) @(posedge mclk);
    endtask

    // only a deselect ends a command; clock parks low first
    task automatic close_frame();
        sck <= 1'b0;
        repeat (4) @(posedge mclk);
        ce_n  <= 1'b1;
        io_in <= ~io_in;
        repeat (8) @(posedge mclk);
    endtask

    // one byte each way; quad moves nibbles high first, unused lines toggle
    task automatic xbyte(input logic [7:0] b, input logic quad, output logic [7:0] r);
        logic [3:0] q;
        r = 8'h00;
        if (quad) begin
            tick(b[7:4], q);
            r[7:4] = q;
            tick(b[3:0], q);
            r[3:0] = q;
        end else begin
            for (int i = 7; i >= 0; i--) begin
                tick({{3{~b[i]}}, b[i]}, q);
                r[i] = q[1];
            end
        end
    endtask
endmodule

// *** bench/flash_read_params_and_id_tb.sv ***
// self-checking bench for the read-parameter and identification command block
`timescale 1ns/100ps
module flash_read_params_and_id_tb;
    logic        mclk;
    logic        rst_n;
    logic        ce_n;
    logic        sck;
    logic [3:0]  io_in;
    logic [3:0]  io_out;
    logic [3:0]  io_oe;
    logic [2:0]  drive_strength;
    logic [23:0] array_rd_addr;
    logic [7:0]  array_rd_data;
    logic [3:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    int          err_total;
    int          samples_checked;

    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    function automatic logic [7:0] mem_byte(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ a[23:16];
    endfunction

    // array content follows the address one cycle later
    initial array_rd_data = 8'h00;
    always @(posedge mclk) array_rd_data <= mem_byte(array_rd_addr);

    flash_read_params_and_id u_flash_read_params_and_id (
        .mclk(mclk), .rst_n(rst_n), .ce_n(ce_n), .sck(sck), .io_in(io_in),
        .io_out(io_out), .io_oe(io_oe), .drive_strength(drive_strength),
        .array_rd_addr(array_rd_addr), .array_rd_data(array_rd_data),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_byteenable(4'h1),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest)
    );

    spi_host_model u_spi_host_model (
        .mclk(mclk), .ce_n(ce_n), .sck(sck), .io_in(io_in), .io_out(io_out), .io_oe(io_oe)
    );

    task automatic stop_test();
        $display("checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic av_xfer(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        int n = 0;
        avs_address   <= a;
        avs_writedata <= d;
        avs_read      <= ~wr;
        avs_write     <= wr;
        @(posedge mclk);
        while (avs_waitrequest !== 1'b0) begin
            n++;
            if (n > 50) begin
                err_total++;
                stop_test();
            end
            @(posedge mclk);
        end
        q = avs_readdata;
        avs_read  <= 1'b0;
        avs_write <= 1'b0;
        @(posedge mclk);
    endtask

    task automatic rd_reg(input logic [3:0] a, input logic [7:0] exp);
        logic [31:0] q;
        av_xfer(1'b0, a, 32'h0, q);
        check(q, {24'h0, exp});
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        logic [31:0] q;
        av_xfer(1'b1, a, {24'h0, d}, q);
    endtask

    // opcode and n following bytes; the frame stays open
    task automatic cmd(input logic [7:0] op, input logic [23:0] args, input int n,
                       input logic quad);
        logic [7:0] r;
        u_spi_host_model.open_frame();
        u_spi_host_model.xbyte(op, quad, r);
        for (int i = n - 1; i >= 0; i--)
            u_spi_host_model.xbyte(args[8*i +: 8], quad, r);
    endtask

    task automatic expect_byte(input logic [7:0] exp, input logic quad);
        logic [7:0] r;
        u_spi_host_model.xbyte(8'ha5, quad, r);
        check({24'h0, r}, {24'h0, exp});
    endtask

    // a refused command leaves the pins undriven
    task automatic expect_quiet(input logic [7:0] op, input int n);
        logic [7:0] r;
        cmd(op, 24'h0, n, 1'b0);
        u_spi_host_model.xbyte(8'ha5, 1'b0, r);
        check({28'h0, u_spi_host_model.oe_seen}, 32'h0);
        u_spi_host_model.close_frame();
    endtask

    initial begin
        logic [23:0] a;
        logic [7:0]  v;
        logic [23:0] m;
        rst_n         = 1'b0;
        avs_address   = 4'h0;
        avs_read      = 1'b0;
        avs_write     = 1'b0;
        avs_writedata = 32'h0;
        err_total       = 0;
        samples_checked = 0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        check({29'h0, drive_strength}, {29'h0, flash_id_pkg::DRIVE_HALF});
        rd_reg(flash_id_pkg::OFS_READ_REG, flash_id_pkg::READ_REG_RESET);
        rd_reg(4'hc, 8'h00);
        $display("test reset done");

        cmd(flash_id_pkg::CMD_STD_ID, 24'h0, 0, 1'b0);
        repeat (2) begin
            expect_byte(flash_id_pkg::MAKER_CODE_DEF, 1'b0);
            expect_byte(flash_id_pkg::TYPE_CAP_CODE_DEF[15:8], 1'b0);
            expect_byte(flash_id_pkg::TYPE_CAP_CODE_DEF[7:0], 1'b0);
        end
        check({28'h0, u_spi_host_model.oe_seen}, {28'h0, flash_id_pkg::OE_SINGLE});
        u_spi_host_model.close_frame();
        cmd(flash_id_pkg::CMD_LEGACY_ID, 24'h0, 3, 1'b0);
        repeat (3) expect_byte(flash_id_pkg::DEVICE_CODE_DEF, 1'b0);
        u_spi_host_model.close_frame();
        for (int k = 0; k < 2; k++) begin
            cmd(flash_id_pkg::CMD_MAKER_DEV_ID, 24'(k), 3, 1'b0);
            repeat (2) begin
                expect_byte(k ? flash_id_pkg::DEVICE_CODE_DEF : flash_id_pkg::MAKER_CODE_DEF,
                            1'b0);
                expect_byte(k ? flash_id_pkg::MAKER_CODE_DEF : flash_id_pkg::DEVICE_CODE_DEF,
                            1'b0);
            end
            u_spi_host_model.close_frame();
        end
        $display("test id reads done");

        // every burst size with wrap off and on, each with its own drive strength, then a read crossing the wrap point
        for (int s = 0; s < 8; s++) begin
            v = {3'(7 - s), 2'b00, 3'(s)};
            cmd(flash_id_pkg::CMD_SET_READ_PARAMS, {16'h0, v}, 1, 1'b0);
            u_spi_host_model.close_frame();
            rd_reg(flash_id_pkg::OFS_READ_REG, v);
            check({29'h0, drive_strength}, {29'h0, 3'(7 - s)});
            cmd(flash_id_pkg::CMD_READ, 24'h0001fe, 3, 1'b0);
            a = 24'h0001fe;
            m = 24'((8 << s[1:0]) - 1);
            repeat (10) begin
                expect_byte(mem_byte(a), 1'b0);
                a = s[2] ? ((a & ~m) | ((a + 24'h1) & m)) : a + 24'h1;
            end
            u_spi_host_model.close_frame();
        end
        $display("test read parameters done");

        wr_reg(flash_id_pkg::OFS_CTRL, 8'h01);
        cmd(flash_id_pkg::CMD_STD_ID_QUAD, 24'h0, 0, 1'b1);
        expect_byte(flash_id_pkg::MAKER_CODE_DEF, 1'b1);
        expect_byte(flash_id_pkg::TYPE_CAP_CODE_DEF[15:8], 1'b1);
        check({28'h0, u_spi_host_model.oe_seen}, {28'h0, flash_id_pkg::OE_QUAD});
        u_spi_host_model.close_frame();
        cmd(flash_id_pkg::CMD_LEGACY_ID, 24'h0, 3, 1'b1);
        expect_byte(flash_id_pkg::DEVICE_CODE_DEF, 1'b1);
        u_spi_host_model.close_frame();
        cmd(flash_id_pkg::CMD_STD_ID, 24'h0, 0, 1'b1);
        expect_byte(flash_id_pkg::MAKER_CODE_DEF, 1'b1);
        u_spi_host_model.close_frame();
        cmd(flash_id_pkg::CMD_SET_READ_PARAMS, 24'h000066, 1, 1'b1);
        u_spi_host_model.close_frame();
        rd_reg(flash_id_pkg::OFS_READ_REG, 8'h66);
        check({29'h0, drive_strength}, 32'h00000003);
        wr_reg(flash_id_pkg::OFS_CTRL, 8'h00);
        expect_quiet(flash_id_pkg::CMD_STD_ID_QUAD, 0);
        $display("test quad done");

        wr_reg(flash_id_pkg::OFS_PWRDN, 8'h01);
        rd_reg(flash_id_pkg::OFS_PWRDN, 8'h01);
        expect_quiet(flash_id_pkg::CMD_STD_ID, 0);
        wr_reg(flash_id_pkg::OFS_CTRL, 8'h02);
        expect_quiet(flash_id_pkg::CMD_LEGACY_ID, 3);
        rd_reg(flash_id_pkg::OFS_PWRDN, 8'h01);
        wr_reg(flash_id_pkg::OFS_CTRL, 8'h00);
        cmd(flash_id_pkg::CMD_LEGACY_ID, 24'h0, 0, 1'b0);
        u_spi_host_model.close_frame();
        rd_reg(flash_id_pkg::OFS_PWRDN, 8'h00);
        $display("test power-down done");

        // wrap was left on; a reset must restore the defaults
        rst_n <= 1'b0;
        repeat (5) @(posedge mclk);
        rst_n <= 1'b1;
        repeat (4) @(posedge mclk);
        rd_reg(flash_id_pkg::OFS_READ_REG, flash_id_pkg::READ_REG_RESET);
        $display("test second reset done");
        stop_test();
    end
endmodule
